// File: include/lfs_regs.svh
`ifndef LFS_REGS_SVH
`define LFS_REGS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define LFS_ADDR_CURRENT 8'h00
`define LFS_ADDR_TIMER 8'h01
`define LFS_ADDR_TRIGGER 8'h02
`define LFS_ADDR_STATUS 8'h03

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define LFS_CUR_MAIN_MSB 7
`define LFS_CUR_MAIN_LSB 3
`define LFS_CUR_IND_MSB 2
`define LFS_CUR_IND_LSB 0
`define LFS_TMR_TIMED_BIT 4
`define LFS_TMR_SEL_MSB 3
`define LFS_TMR_SEL_LSB 0
`define LFS_TRIG_BIT 0
`define LFS_ST_OVERVOLT 0
`define LFS_ST_TIMEOUT 1
`define LFS_ST_OVERTEMP 2
`define LFS_ST_SHORT 3

// ----------------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------------
`define LFS_RST_CURRENT 8'h00
`define LFS_RST_TIMER 8'h00
`define LFS_RST_TRIGGER 8'h00
`define LFS_RECOVER_VALUE 8'h00
`define LFS_FLASH_MIN_LEVEL 5'h0C

// ----------------------------------------------------------------------
// timing and currents
// ----------------------------------------------------------------------
`define LFS_CLK_MHZ 25
`define LFS_TIMEOUT_US 820000
`define LFS_TIMED_STEP_US 54600
`define LFS_RAMP_UP_UA_PER_US 4500
`define LFS_RAMP_DN_UA_PER_US 9000
`define LFS_MAIN_BASE_UA 35000
`define LFS_MAIN_STEP_UA 15000
`define LFS_DIRECT_TORCH_UA 125000
`define LFS_DIRECT_FLASH_UA 500000
`define LFS_IND_STEP_UA 2500
`define LFS_IND_DIRECT_UA 10000

`endif

// File: include/lfs_pkg.sv
package lfs_pkg;

   // ----------------------------------------------------------------------
   // types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      LFS_ST_IDLE,
      LFS_ST_TORCH,
      LFS_ST_FLASH
   } lfs_mode_e;

   // protection comparator outputs
   typedef struct packed {
      logic output_short;
      logic overtemp;
      logic overvoltage;
   } lfs_mon_s;

   typedef struct packed {
      logic [4:0] main_level;
      logic [2:0] ind_level;
      logic timed_flash_select;
      logic [3:0] timer_select;
      logic soft_flash_trigger;
   } lfs_regs_s;

   typedef struct packed {
      logic output_short_flag;
      logic overtemp_flag;
      logic timeout_flag;
      logic overvoltage_flag;
   } lfs_flags_s;

   typedef struct packed {
      lfs_mode_e mode;
      lfs_regs_s regs;
      lfs_flags_s flags;
      logic [24:0] timer;
      logic trig_prev;
      logic hw_prev;
      logic [18:0] main_ua;
      logic [14:0] ind_ua;
      logic conv_en;
      logic int_drive;
      logic [7:0] rdata;
   } lfs_state_s;

endpackage

// File: core/lfs_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
`include "lfs_regs.svh"

// Operation
// - any protection event stops switching, latches its cause, pulls interrupt low.
// - protection drops main current to zero at once and turns indicator off.
// - serial mode: writing zero to current control clears flags, releases interrupt.
// - fault leaves all registers except status untouched.
// - direct mode: both enable lines low clears flags, releases interrupt.
// - interrupt output works in direct mode as well.
// - overvoltage inhibits switching and sets status bit 0.
// - untimed or direct flash is capped at 820 ms by time-out timer.
// - serial mode: falling hardware trigger clears software trigger bit.
// - direct mode: first enable falling before time-out resets the timer.
// - untimed flash time-out is a fault setting status bit 1.
// - overtemperature sets bit 2; switching held off while still too hot.
// - output short in torch mode or during flash ramp-up sets status bit 3.
// - interrupt is active-low open drain for wired-OR sharing.
// - low supply lockout halts everything and restores register defaults.
// - low supply lockout raises no interrupt and sets no flag.
// - current rises at most 4.5 mA/us until target reached.
// - normal end ramps current down at 9 mA/us.
// - serial mode indicator current is 3-bit setting times 2.5 mA.
// - direct mode indicator current is 10 mA while only enable line B is high.
// - timed flash ending normally raises nothing and allows immediate reflash.
module lfs_supervisor
   import lfs_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYCLES =
      `LFS_TIMEOUT_US * `LFS_CLK_MHZ,
   parameter int unsigned TIMED_STEP_CYCLES =
      `LFS_TIMED_STEP_US * `LFS_CLK_MHZ
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // supply and control mode
   input wire logic low_supply_lockout,
   input wire logic serial_mode,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // direct pins
   input wire logic enable_line_a,
   input wire logic enable_line_b,
   input wire logic hw_flash_trigger,
   // protection monitors
   input wire lfs_mon_s monitors,
   // converter and current sinks
   output logic converter_enable,
   output logic [18:0] main_current_ua,
   output logic [14:0] indicator_current_ua,
   // fault interrupt, open drain
   output logic fault_int_o,
   output logic fault_int_oe
);

   // ----------------------------------------------------------------------
   // constants
   // ----------------------------------------------------------------------
   localparam logic [18:0] RAMP_UP_STEP =
      19'(`LFS_RAMP_UP_UA_PER_US / `LFS_CLK_MHZ);
   localparam logic [18:0] RAMP_DN_STEP =
      19'(`LFS_RAMP_DN_UA_PER_US / `LFS_CLK_MHZ);
   localparam logic [24:0] TIMEOUT_CNT = 25'(TIMEOUT_CYCLES);
   localparam logic [7:0] REG_RST = `LFS_RST_CURRENT | `LFS_RST_TIMER |
      `LFS_RST_TRIGGER;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic logic [18:0] main_target(input logic serial,
      input lfs_mode_e m, input logic [4:0] lvl);
      logic [18:0] t;
      t = 19'h00000;
      if (m == LFS_ST_IDLE) begin
         t = 19'h00000;
      end else if (serial) begin
         t = 19'(`LFS_MAIN_BASE_UA + `LFS_MAIN_STEP_UA * int'(lvl));
      end else if (m == LFS_ST_FLASH) begin
         t = 19'(`LFS_DIRECT_FLASH_UA);
      end else begin
         t = 19'(`LFS_DIRECT_TORCH_UA);
      end
      return t;
   endfunction

   function automatic logic [24:0] timed_limit(input logic [3:0] sel);
      return 25'(TIMEOUT_CYCLES - TIMED_STEP_CYCLES * int'(sel));
   endfunction

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   lfs_state_s s_q;
   lfs_state_s s_d;
   lfs_regs_s reg_rst;
   lfs_flags_s set_f;
   logic recover;
   logic trig_lvl;
   logic trig_rise;
   logic torch_req;
   logic flash_start;
   logic flash_stop;
   logic flash_timeout;
   logic timed_done;
   logic fault_any;
   logic [18:0] target;
   logic [18:0] diff;

   assign reg_rst = lfs_regs_s'(14'(REG_RST));

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      set_f = '0;
      trig_lvl = s_q.regs.soft_flash_trigger | hw_flash_trigger;
      trig_rise = trig_lvl & ~s_q.trig_prev;
      s_d.trig_prev = trig_lvl;
      s_d.hw_prev = hw_flash_trigger;

      // mode requests
      torch_req = 1'b0;
      flash_start = 1'b0;
      flash_stop = 1'b0;
      if (serial_mode) begin
         torch_req = (s_q.regs.main_level != 5'h00) &&
            (s_q.regs.main_level < `LFS_FLASH_MIN_LEVEL);
         if (s_q.regs.main_level >= `LFS_FLASH_MIN_LEVEL) begin
            flash_start = s_q.regs.timed_flash_select ? trig_rise : trig_lvl;
            flash_stop = ~s_q.regs.timed_flash_select & ~trig_lvl;
         end else begin
            flash_stop = 1'b1;
         end
      end else begin
         torch_req = enable_line_a & ~enable_line_b;
         flash_start = enable_line_a & enable_line_b;
         flash_stop = ~(enable_line_a & enable_line_b);
      end

      // flash timing
      timed_done = serial_mode && s_q.regs.timed_flash_select &&
         (s_q.timer >= timed_limit(s_q.regs.timer_select));
      flash_timeout = (s_q.mode == LFS_ST_FLASH) && !timed_done &&
         !(serial_mode && s_q.regs.timed_flash_select) &&
         (s_q.timer >= TIMEOUT_CNT - 25'h0000001);

      // protection events
      target = main_target(serial_mode, s_q.mode, s_q.regs.main_level);
      set_f.overvoltage_flag = monitors.overvoltage;
      set_f.timeout_flag = flash_timeout;
      set_f.overtemp_flag = monitors.overtemp;
      set_f.output_short_flag = monitors.output_short &&
         ((s_q.mode == LFS_ST_TORCH) ||
         (s_q.mode == LFS_ST_FLASH && s_q.main_ua < target));

      // recovery clears, new events win
      recover = serial_mode ? (reg_wr && reg_addr == `LFS_ADDR_CURRENT &&
         reg_wdata == `LFS_RECOVER_VALUE)
         : (~enable_line_a & ~enable_line_b);
      s_d.flags = (recover ? lfs_flags_s'(4'h0) : s_q.flags) | set_f;
      fault_any = |s_d.flags;

      // mode sequencing
      case (s_q.mode)
         LFS_ST_IDLE: begin
            if (flash_start) begin
               s_d.mode = LFS_ST_FLASH;
            end else if (torch_req) begin
               s_d.mode = LFS_ST_TORCH;
            end
         end
         LFS_ST_TORCH: begin
            if (flash_start) begin
               s_d.mode = LFS_ST_FLASH;
            end else if (!torch_req) begin
               s_d.mode = LFS_ST_IDLE;
            end
         end
         LFS_ST_FLASH: begin
            if (timed_done) begin
               s_d.mode = LFS_ST_IDLE;
               s_d.regs.soft_flash_trigger = 1'b0;
            end else if (flash_stop) begin
               s_d.mode = torch_req ? LFS_ST_TORCH : LFS_ST_IDLE;
            end
         end
         default: begin
            s_d.mode = LFS_ST_IDLE;
         end
      endcase
      if (fault_any) begin
         s_d.mode = LFS_ST_IDLE;
      end
      s_d.timer = (s_d.mode == LFS_ST_FLASH && s_q.mode == LFS_ST_FLASH) ?
         s_q.timer + 25'h0000001 : 25'h0000000;

      // register writes, other registers survive faults
      if (serial_mode && s_q.hw_prev && !hw_flash_trigger) begin
         s_d.regs.soft_flash_trigger = 1'b0;
      end
      if (reg_wr) begin
         if (reg_addr == `LFS_ADDR_CURRENT) begin
            s_d.regs.main_level =
               reg_wdata[`LFS_CUR_MAIN_MSB:`LFS_CUR_MAIN_LSB];
            s_d.regs.ind_level = reg_wdata[`LFS_CUR_IND_MSB:`LFS_CUR_IND_LSB];
         end else if (reg_addr == `LFS_ADDR_TIMER) begin
            s_d.regs.timed_flash_select = reg_wdata[`LFS_TMR_TIMED_BIT];
            s_d.regs.timer_select =
               reg_wdata[`LFS_TMR_SEL_MSB:`LFS_TMR_SEL_LSB];
         end else if (reg_addr == `LFS_ADDR_TRIGGER) begin
            s_d.regs.soft_flash_trigger = reg_wdata[`LFS_TRIG_BIT];
         end
      end

      // register reads
      if (reg_rd) begin
         if (reg_addr == `LFS_ADDR_CURRENT) begin
            s_d.rdata = {s_q.regs.main_level, s_q.regs.ind_level};
         end else if (reg_addr == `LFS_ADDR_TIMER) begin
            s_d.rdata = {3'h0, s_q.regs.timed_flash_select,
               s_q.regs.timer_select};
         end else if (reg_addr == `LFS_ADDR_TRIGGER) begin
            s_d.rdata = {7'h00, s_q.regs.soft_flash_trigger};
         end else if (reg_addr == `LFS_ADDR_STATUS) begin
            s_d.rdata = {4'h0, s_q.flags};
         end else begin
            s_d.rdata = 8'h00;
         end
      end

      // main current slopes
      target = main_target(serial_mode, s_d.mode, s_d.regs.main_level);
      if (s_q.main_ua < target) begin
         diff = target - s_q.main_ua;
         s_d.main_ua = s_q.main_ua +
            ((diff < RAMP_UP_STEP) ? diff : RAMP_UP_STEP);
      end else begin
         diff = s_q.main_ua - target;
         s_d.main_ua = s_q.main_ua -
            ((diff < RAMP_DN_STEP) ? diff : RAMP_DN_STEP);
      end
      if (fault_any) begin
         s_d.main_ua = 19'h00000;
      end

      // indicator current
      if (serial_mode) begin
         s_d.ind_ua = 15'(`LFS_IND_STEP_UA * int'(s_d.regs.ind_level));
      end else if (~enable_line_a & enable_line_b) begin
         s_d.ind_ua = 15'(`LFS_IND_DIRECT_UA);
      end else begin
         s_d.ind_ua = 15'h0000;
      end
      if (fault_any) begin
         s_d.ind_ua = 15'h0000;
      end

      // converter and interrupt
      s_d.conv_en = !fault_any && !monitors.overtemp &&
         (s_d.mode != LFS_ST_IDLE || s_d.main_ua != 19'h00000);
      s_d.int_drive = fault_any;

      // lockout wipes everything without flagging
      if (low_supply_lockout) begin
         s_d = '0;
         s_d.mode = LFS_ST_IDLE;
         s_d.regs = reg_rst;
      end
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign reg_rdata = s_q.rdata;
   assign converter_enable = s_q.conv_en;
   assign main_current_ua = s_q.main_ua;
   assign indicator_current_ua = s_q.ind_ua;
   assign fault_int_o = 1'b0;
   assign fault_int_oe = s_q.int_drive;

endmodule // lfs_supervisor

`default_nettype wire

// File: sim/lfs_host_line.sv
`timescale 1ns/1ps
`default_nettype none
module lfs_host_line (
   // device side
   input wire logic fault_int_o,
   input wire logic fault_int_oe,
   // host side
   output logic int_line_n
);
   // single pull-up, low while any party pulls
   assign int_line_n = fault_int_oe ? fault_int_o : 1'b1;
endmodule // lfs_host_line
`default_nettype wire

// File: sim/lfs_supervisor_props.sv
`timescale 1ns/1ps
`default_nettype none
module lfs_supervisor_props
   import lfs_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // inputs
   input wire logic low_supply_lockout,
   input wire logic serial_mode,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic enable_line_a,
   input wire logic enable_line_b,
   input wire logic hw_flash_trigger,
   input wire lfs_mon_s monitors,
   // outputs
   input wire logic [7:0] reg_rdata,
   input wire logic converter_enable,
   input wire logic [18:0] main_current_ua,
   input wire logic [14:0] indicator_current_ua,
   input wire logic fault_int_o,
   input wire logic fault_int_oe
);
   logic recover;
   assign recover = serial_mode ? (reg_wr && reg_addr == 8'h00 &&
      reg_wdata == 8'h00) : (!enable_line_a && !enable_line_b);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   ov_trip_int_a: assert property (monitors.overvoltage &&
      !low_supply_lockout |=> fault_int_oe && !converter_enable &&
      main_current_ua == 19'h0 && indicator_current_ua == 15'h0)
      else $error("overvoltage not handled");
   ot_inhibit_a: assert property (monitors.overtemp |=>
      !converter_enable) else $error("switching while hot");
   flag_hold_a: assert property (fault_int_oe && !recover &&
      !low_supply_lockout |=> fault_int_oe) else $error("interrupt lost");
   fault_recover_a: assert property (fault_int_oe && recover &&
      monitors == 3'h0 && !low_supply_lockout |=> !fault_int_oe)
      else $error("interrupt not released");
   lockout_quiet_a: assert property (low_supply_lockout |=>
      !fault_int_oe && !converter_enable && main_current_ua == 19'h0)
      else $error("lockout left activity");
   int_open_drain_a: assert property (fault_int_o == 1'b0)
      else $error("interrupt drives high");
   ramp_up_a: assert property (main_current_ua > $past(main_current_ua)
      |-> main_current_ua - $past(main_current_ua) <= 19'h0B4)
      else $error("rise too steep");
   ramp_down_a: assert property (!fault_int_oe &&
      !$past(low_supply_lockout) &&
      main_current_ua < $past(main_current_ua) |->
      $past(main_current_ua) - main_current_ua <= 19'h168)
      else $error("fall too steep");
endmodule // lfs_supervisor_props

bind lfs_supervisor lfs_supervisor_props i_props (
   .clk(clk), .arst_n(arst_n), .low_supply_lockout(low_supply_lockout),
   .serial_mode(serial_mode), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .enable_line_a(enable_line_a), .enable_line_b(enable_line_b),
   .hw_flash_trigger(hw_flash_trigger), .monitors(monitors),
   .converter_enable(converter_enable), .main_current_ua(main_current_ua),
   .indicator_current_ua(indicator_current_ua),
   .fault_int_o(fault_int_o), .fault_int_oe(fault_int_oe));
`default_nettype wire

// File: sim/lfs_supervisor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lfs_supervisor_tb
   import lfs_pkg::*;
;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic lockout = 1'b0;
   logic serial = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic en_a = 1'b0;
   logic en_b = 1'b0;
   logic hw = 1'b0;
   lfs_mon_s mon = '0;
   logic [7:0] rdata;
   logic conv, int_o, int_oe, int_n;
   logic [18:0] main_ua;
   logic [14:0] ind_ua;
   int miscompares = 0;
   int n_checks = 0;

   always #20 clk = ~clk;

   lfs_supervisor #(.TIMEOUT_CYCLES(1000), .TIMED_STEP_CYCLES(60)) i_dut (
      .clk(clk), .arst_n(arst_n), .low_supply_lockout(lockout),
      .serial_mode(serial), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
      .reg_wdata(wdata), .reg_rdata(rdata), .enable_line_a(en_a),
      .enable_line_b(en_b), .hw_flash_trigger(hw), .monitors(mon),
      .converter_enable(conv), .main_current_ua(main_ua),
      .indicator_current_ua(ind_ua), .fault_int_o(int_o),
      .fault_int_oe(int_oe));
   lfs_host_line i_host (.fault_int_o(int_o), .fault_int_oe(int_oe),
      .int_line_n(int_n));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      cyc(1);
      wr = 1'b1;
      addr = a;
      wdata = d;
      cyc(1);
      wr = 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      cyc(1);
      rd = 1'b1;
      addr = a;
      cyc(1);
      rd = 1'b0;
      chk(rdata, e);
   endtask
   task automatic wait_int(input int lim, output int n);
      n = 0;
      while (int_oe !== 1'b1) begin
         if (n == lim) begin
            miscompares++;
            finish_test();
         end
         cyc(1);
         n++;
      end
   endtask

   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   task automatic t_monitors();
      logic [7:0] st [3] = '{8'h01, 8'h04, 8'h08};
      wr_reg(8'h01, 8'h13);
      for (int i = 0; i < 3; i++) begin
         wr_reg(8'h00, 8'h59);
         cyc(10);
         chk(ind_ua, 15'h09C4);
         chk(main_ua, 19'h00708);
         chk(conv, 1'b1);
         mon = lfs_mon_s'(3'h1 << i);
         cyc(1);
         mon = '0;
         chk({int_n, conv, main_ua}, 21'h0);
         chk(ind_ua, 15'h0);
         cyc(5);
         chk(int_n, 1'b0);
         rd_chk(8'h03, st[i]);
         wr_reg(8'h00, 8'h00);
         chk(int_n, 1'b1);
         rd_chk(8'h03, 8'h00);
      end
      rd_chk(8'h01, 8'h13);
   endtask
   task automatic t_flash();
      int n;
      wr_reg(8'h01, 8'h00);
      wr_reg(8'h00, 8'h60);
      wr_reg(8'h02, 8'h01);
      wait_int(1100, n);
      chk(n >= 990 && n <= 1002, 1'b1);
      rd_chk(8'h03, 8'h02);
      wr_reg(8'h02, 8'h00);
      wr_reg(8'h00, 8'h00);
      wr_reg(8'h01, 8'h1F);
      wr_reg(8'h00, 8'h60);
      wr_reg(8'h02, 8'h01);
      cyc(90);
      rd_chk(8'h02, 8'h01);
      cyc(20);
      rd_chk(8'h02, 8'h00);
      chk(int_n, 1'b1);
      rd_chk(8'h03, 8'h00);
      wr_reg(8'h01, 8'h00);
      wr_reg(8'h02, 8'h01);
      hw = 1'b1;
      cyc(3);
      hw = 1'b0;
      cyc(2);
      rd_chk(8'h02, 8'h00);
      wr_reg(8'h00, 8'h00);
      cyc(700);
   endtask
   task automatic t_direct();
      int n;
      serial = 1'b0;
      en_b = 1'b1;
      cyc(3);
      chk(ind_ua, 15'h2710);
      en_a = 1'b1;
      cyc(600);
      en_a = 1'b0;
      cyc(2);
      en_a = 1'b1;
      cyc(900);
      chk(int_n, 1'b1);
      wait_int(200, n);
      chk(int_n, 1'b0);
      en_a = 1'b0;
      en_b = 1'b0;
      cyc(2);
      chk(int_n, 1'b1);
   endtask
   task automatic t_lockout();
      serial = 1'b1;
      wr_reg(8'h01, 8'h15);
      mon.overvoltage = 1'b1;
      cyc(1);
      mon.overvoltage = 1'b0;
      chk(int_n, 1'b0);
      lockout = 1'b1;
      cyc(2);
      lockout = 1'b0;
      chk(int_n, 1'b1);
      rd_chk(8'h01, 8'h00);
      rd_chk(8'h03, 8'h00);
   endtask

   initial begin
      cyc(12);
      arst_n = 1'b1;
      for (int a = 0; a < 5; a++) begin
         rd_chk(8'(a), 8'h00);
      end
      t_monitors();
      t_flash();
      t_direct();
      t_lockout();
      finish_test();
   end
endmodule // lfs_supervisor_tb
`default_nettype wire
